//--- interrupt_status_enable_bank.sv
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "irq_bank_defs.svh"

module interrupt_status_enable_bank
    import irq_bank_pkg::*;
#(
    parameter int AW = 12
)
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire irq_sources_s sources,
    output logic irq
);

    bank_state_s state_ff;
    bank_state_s nxt_state;

    logic access;
    logic wrTake;
    logic rdPhase;
    logic masterInt;
    reg_sel_e wrSel;
    reg_sel_e rdSel;

    function automatic reg_sel_e decodeReg(input logic [AW-1:0] addr);
        reg_sel_e sel;
        sel = SEL_NONE;
        if (addr == AW'(`OFS_STATUS))
        begin
            sel = SEL_STATUS;
        end
        else if (addr == AW'(`OFS_ENABLE))
        begin
            sel = SEL_ENABLE;
        end
        else if (addr == AW'(`OFS_CONTROL))
        begin
            sel = SEL_CONTROL;
        end
        return sel;
    endfunction

    // a byte lane masked out by pstrb leaves those bits untouched
    function automatic logic [31:0] laneMask(input logic [3:0] strb);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    assign access = psel & penable;
    assign wrTake = access & state_ff.pready & pwrite;
    assign rdPhase = access & ~state_ff.pready;
    assign wrSel = decodeReg(paddr);
    assign rdSel = wrSel;
    // internal request line, independent of the output enable
    assign masterInt = |(state_ff.status & state_ff.enable);

    always_comb
    begin
        logic [31:0] setV;
        logic [31:0] clrV;
        logic [31:0] wmask;
        logic [31:0] newEnable;
        setV = '0;
        clrV = '0;
        wmask = pwdata & laneMask(pstrb);
        newEnable = state_ff.enable;
        nxt_state = state_ff;

        // one wait state: pready rises in the second access cycle
        nxt_state.pready = rdPhase;
        nxt_state.readyPrev = sources.deviceReady;

        if (rdPhase)
        begin
            nxt_state.pslverr = (wrSel == SEL_NONE);
            nxt_state.prdata = `RST_RDATA;
            if (!pwrite)
            begin
                unique case (rdSel)
                    SEL_STATUS:
                    begin
                        nxt_state.prdata = state_ff.status
                            & `MASK_DEFINED;
                    end
                    SEL_ENABLE:
                    begin
                        nxt_state.prdata = state_ff.enable
                            & `MASK_DEFINED;
                    end
                    SEL_CONTROL:
                    begin
                        nxt_state.prdata[`BIT_OUT_EN] = state_ff.outEn;
                        nxt_state.prdata[`BIT_MASTER] = masterInt;
                    end
                    SEL_NONE:
                    begin
                        nxt_state.prdata = `RST_RDATA;
                    end
                endcase
            end
        end
        else
        begin
            nxt_state.pslverr = 1'b0;
        end

        if (wrTake && wrSel == SEL_ENABLE)
        begin
            // only defined bits are writable; reserved stay zero
            newEnable = (state_ff.enable & ~laneMask(pstrb))
                | (wmask & `MASK_DEFINED);
        end
        nxt_state.enable = newEnable;

        if (wrTake && wrSel == SEL_CONTROL && pstrb[1])
        begin
            nxt_state.outEn = pwdata[`BIT_OUT_EN];
        end

        // software interrupt fires on the enable bit going high
        setV[`BIT_SOFT] = newEnable[`BIT_SOFT]
            & ~state_ff.enable[`BIT_SOFT];
        setV[`BIT_READY] = sources.deviceReady
            & ~state_ff.readyPrev;
        setV[`BIT_TIMER] = sources.timerWrap;
        setV[`BIT_WAKE] = sources.wakeEvent;

        if (wrTake && wrSel == SEL_STATUS)
        begin
            // ones clear, zeros and read-only bits are ignored
            clrV = wmask & `MASK_W1C;
            if (sources.wakePending)
            begin
                // wake flag survives until its causes are cleared
                clrV[`BIT_WAKE] = 1'b0;
            end
        end

        // set is applied after clear, so a same-cycle event wins
        nxt_state.status = (state_ff.status & ~clrV) | setV;
        nxt_state.status[`BIT_PHY_SECOND] = sources.secondPhyEvent;
        nxt_state.status[`BIT_PHY_FIRST] = sources.firstPhyEvent;
        nxt_state.status[`BIT_FIELDBUS] = sources.fieldbusEvent;
        nxt_state.status = nxt_state.status & `MASK_DEFINED;

        // no de-assertion interval here, so the wake bit goes straight out
        nxt_state.irqPin = nxt_state.outEn
            & |(nxt_state.status & nxt_state.enable);
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff.status <= `RST_STATUS;
            state_ff.enable <= `RST_ENABLE;
            state_ff.outEn <= `RST_OUT_EN;
            state_ff.irqPin <= 1'b0;
            state_ff.readyPrev <= 1'b0;
            state_ff.pready <= 1'b0;
            state_ff.pslverr <= 1'b0;
            state_ff.prdata <= `RST_RDATA;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign prdata = state_ff.prdata;
    assign pready = state_ff.pready;
    assign pslverr = state_ff.pslverr;
    assign irq = state_ff.irqPin;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    logic statusWrite;
    logic enableWrite;
    assign statusWrite = wrTake && wrSel == SEL_STATUS;
    assign enableWrite = wrTake && wrSel == SEL_ENABLE;

    chk_apb_wait: assert property (
        rdPhase |=> pready ##1 !pready)
        else $error("pready not one cycle after access start");

    chk_timer_w1c: assert property (
        statusWrite && pwdata[`BIT_TIMER] && pstrb[2]
            && !sources.timerWrap
        |=> !state_ff.status[`BIT_TIMER])
        else $error("timer flag not cleared by write one");

    chk_set_wins: assert property (
        sources.timerWrap |=> state_ff.status[`BIT_TIMER])
        else $error("timer wrap event lost");

    chk_zero_keeps: assert property (
        statusWrite && pwdata == 32'h00000000 && state_ff.status[`BIT_READY]
        |=> state_ff.status[`BIT_READY])
        else $error("zero write changed ready flag");

    chk_soft_set: assert property (
        enableWrite && pwdata[`BIT_SOFT] && pstrb[3]
            && !state_ff.enable[`BIT_SOFT]
        |=> state_ff.status[`BIT_SOFT])
        else $error("soft flag not set by enable");

    chk_ready_edge: assert property (
        sources.deviceReady && !$past(sources.deviceReady)
        |-> ##1 state_ff.status[`BIT_READY])
        else $error("ready flag missed rising edge");

    chk_phy_mirror: assert property (
        ##1 state_ff.status[`BIT_PHY_SECOND] == $past(sources.secondPhyEvent)
            && state_ff.status[`BIT_PHY_FIRST]
                == $past(sources.firstPhyEvent))
        else $error("phy flags do not follow sources");

    chk_fieldbus_mirror: assert property (
        ##1 state_ff.status[`BIT_FIELDBUS] == $past(sources.fieldbusEvent))
        else $error("fieldbus flag does not follow source");

    chk_wake_hold: assert property (
        statusWrite && sources.wakePending && state_ff.status[`BIT_WAKE]
        |=> state_ff.status[`BIT_WAKE])
        else $error("wake flag cleared while causes pending");

    chk_wake_set: assert property (
        sources.wakeEvent |=> state_ff.status[`BIT_WAKE])
        else $error("wake event not recorded");

    chk_irq_level: assert property (
        irq == (state_ff.outEn && |(state_ff.status & state_ff.enable)))
        else $error("irq does not match enabled status");

    chk_irq_gate: assert property (
        !state_ff.outEn |-> !irq)
        else $error("irq asserted while output disabled");

    chk_wake_direct: assert property (
        sources.wakeEvent && state_ff.outEn && state_ff.enable[`BIT_WAKE]
            && !(enableWrite || (wrTake && wrSel == SEL_CONTROL))
        |=> irq)
        else $error("wake interrupt delayed");

    chk_reserved_zero: assert property (
        (state_ff.status & ~`MASK_DEFINED) == 32'h00000000
            && (state_ff.enable & ~`MASK_DEFINED) == 32'h00000000)
        else $error("reserved bit set");

    chk_status_indep: assert property (
        sources.timerWrap && !state_ff.enable[`BIT_TIMER]
        |=> state_ff.status[`BIT_TIMER])
        else $error("status depends on enable");

    chk_err_unmapped: assert property (
        rdPhase && wrSel == SEL_NONE |=> pslverr && pready)
        else $error("unmapped access without error response");

    chk_err_with_ready: assert property (
        pslverr |-> pready)
        else $error("error response outside ready cycle");

    chk_status_read: assert property (
        rdPhase && !pwrite && rdSel == SEL_STATUS
        |=> prdata == ($past(state_ff.status) & `MASK_DEFINED))
        else $error("status read data wrong");

    chk_enable_read: assert property (
        rdPhase && !pwrite && rdSel == SEL_ENABLE
        |=> prdata == ($past(state_ff.enable) & `MASK_DEFINED))
        else $error("enable read data wrong");

    chk_master_read: assert property (
        rdPhase && !pwrite && rdSel == SEL_CONTROL
        |=> prdata[`BIT_MASTER] == $past(masterInt))
        else $error("master indication read wrong");

    chk_out_en_write: assert property (
        wrTake && wrSel == SEL_CONTROL && pstrb[1]
        |=> state_ff.outEn == $past(pwdata[`BIT_OUT_EN]))
        else $error("output enable not written");

    chk_enable_stable: assert property (
        !enableWrite |=> $stable(state_ff.enable))
        else $error("enable changed without a write");

    chk_soft_only: assert property (
        !(enableWrite && pstrb[3] && pwdata[`BIT_SOFT])
            && !state_ff.status[`BIT_SOFT]
        |=> !state_ff.status[`BIT_SOFT])
        else $error("soft flag set without enable write");

    chk_ready_clear: assert property (
        statusWrite && pstrb[3] && pwdata[`BIT_READY]
            && !sources.deviceReady
        |=> !state_ff.status[`BIT_READY])
        else $error("ready flag not cleared by write one");

    chk_timer_sticky: assert property (
        state_ff.status[`BIT_TIMER] && !statusWrite
        |=> state_ff.status[`BIT_TIMER])
        else $error("timer flag dropped without a clear");

    cov_irq_raise: cover property (!irq ##1 irq);
    cov_unmapped_access: cover property (
        rdPhase && wrSel == SEL_NONE);
    cov_w1c_clear: cover property (
        statusWrite && state_ff.status[`BIT_TIMER] && !sources.timerWrap);
    cov_set_clear_race: cover property (
        statusWrite && pwdata[`BIT_TIMER] && sources.timerWrap);
    cov_wake_blocked: cover property (
        statusWrite && pwdata[`BIT_WAKE] && sources.wakePending);

endmodule

//--- irq_bank_defs.svh
`ifndef IRQ_BANK_DEFS_SVH
`define IRQ_BANK_DEFS_SVH

// register byte offsets
`define OFS_CONTROL 12'h054
`define OFS_STATUS 12'h058
`define OFS_ENABLE 12'h05C

// status and enable bit positions (shared layout)
`define BIT_SOFT 31
`define BIT_READY 30
`define BIT_PHY_SECOND 27
`define BIT_PHY_FIRST 26
`define BIT_TIMER 19
`define BIT_WAKE 17
`define BIT_FIELDBUS 0

// control register bit positions
`define BIT_OUT_EN 8
`define BIT_MASTER 12

// masks and reset values
`define MASK_DEFINED 32'hCC0A0001
`define MASK_W1C 32'hC00A0000
`define RST_STATUS 32'h00000000
`define RST_ENABLE 32'h00000000
`define RST_OUT_EN 1'h0
`define RST_RDATA 32'h00000000

`endif

//--- irq_bank_pkg.sv
package irq_bank_pkg;

    // one-hot register select produced by the address decoder
    typedef enum logic [3:0] {
        SEL_NONE = 4'h1,
        SEL_CONTROL = 4'h2,
        SEL_STATUS = 4'h4,
        SEL_ENABLE = 4'h8
    } reg_sel_e;

    // event and level inputs from the surrounding device
    typedef struct packed {
        logic deviceReady;
        logic secondPhyEvent;
        logic firstPhyEvent;
        logic timerWrap;
        logic wakeEvent;
        logic wakePending;
        logic fieldbusEvent;
    } irq_sources_s;

    // complete state of the bank
    typedef struct packed {
        logic [31:0] status;
        logic [31:0] enable;
        logic outEn;
        logic irqPin;
        logic readyPrev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } bank_state_s;

endpackage

//--- irq_source_model.sv
`timescale 1ns/1ps

module irq_source_model
    import irq_bank_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    output irq_sources_s sources
);
    int cnt;

    initial sources = '0;

    // the device needs a few cycles before it takes host accesses
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt <= 0;
            sources.deviceReady <= 1'b0;
        end
        else if (cnt < 8)
            cnt <= cnt + 1;
        else
            sources.deviceReady <= 1'b1;
    end

    // one-cycle pulse: 0 timer wrap, 1 wake event
    task pulse(input int which);
        @(posedge clock);
        if (which == 1)
            sources.wakeEvent <= 1'b1;
        else
            sources.timerWrap <= 1'b1;
        @(posedge clock);
        sources.wakeEvent <= 1'b0;
        sources.timerWrap <= 1'b0;
    endtask

    // pending stays up until the host clears its power-mgmt causes
    task level(input logic s, input logic f, input logic b, input logic p);
        @(posedge clock);
        sources.secondPhyEvent <= s;
        sources.firstPhyEvent <= f;
        sources.fieldbusEvent <= b;
        sources.wakePending <= p;
    endtask
endmodule

//--- tb_interrupt_status_enable_bank.sv
`timescale 1ns/1ps
`include "irq_bank_defs.svh"

module tb_interrupt_status_enable_bank
    import irq_bank_pkg::*;
;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] strb = 4'hF;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, irq, err;
    irq_sources_s sources;
    int mismatches = 0;
    int checks = 0;

    always #5 clock = ~clock;

    interrupt_status_enable_bank dut (.clock(clock), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sources(sources), .irq(irq));

    irq_source_model sm (.clock(clock), .resetn(resetn), .sources(sources));

    task check(input string name, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task give_verdict;
        if (mismatches == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        check("read", rd, e);
    endtask

    task irqchk(input logic e);
        @(negedge clock);
        check("irq", {31'h0, irq}, {31'h0, e});
    endtask

    task t_reset;
        rdchk(`OFS_STATUS, 32'h40000000);
        rdchk(`OFS_ENABLE, 32'h00000000);
        rdchk(`OFS_CONTROL, 32'h00000000);
        apb(1'b1, `OFS_STATUS, 32'h40000000);
        rdchk(`OFS_STATUS, 32'h00000000);
    endtask

    task t_map;
        apb(1'b1, 12'h060, 32'hFFFFFFFF);
        check("werr", {31'h0, err}, 32'h00000001);
        apb(1'b0, 12'h060, 32'h00000000);
        check("rerr", {31'h0, err}, 32'h00000001);
        check("rdata", rd, 32'h00000000);
    endtask

    task t_soft;
        strb <= 4'h7;
        apb(1'b1, `OFS_ENABLE, 32'hFFFFFFFF);
        strb <= 4'hF;
        rdchk(`OFS_ENABLE, 32'h000A0001);
        rdchk(`OFS_STATUS, 32'h00000000);
        apb(1'b1, `OFS_ENABLE, 32'hFFFFFFFF);
        rdchk(`OFS_ENABLE, 32'hCC0A0001);
        rdchk(`OFS_STATUS, 32'h80000000);
        irqchk(1'b0);
        rdchk(`OFS_CONTROL, 32'h00001000);
        apb(1'b1, `OFS_CONTROL, 32'h00000100);
        irqchk(1'b1);
        apb(1'b1, `OFS_STATUS, 32'h00000000);
        rdchk(`OFS_STATUS, 32'h80000000);
        apb(1'b1, `OFS_STATUS, 32'h80000000);
        rdchk(`OFS_STATUS, 32'h00000000);
        irqchk(1'b0);
    endtask

    task t_mirror;
        sm.level(1'b1, 1'b1, 1'b1, 1'b0);
        rdchk(`OFS_STATUS, 32'h0C000001);
        irqchk(1'b1);
        apb(1'b1, `OFS_STATUS, 32'h0C000001);
        rdchk(`OFS_STATUS, 32'h0C000001);
        sm.level(1'b0, 1'b0, 1'b0, 1'b0);
        rdchk(`OFS_STATUS, 32'h00000000);
    endtask

    task t_wake;
        apb(1'b1, `OFS_ENABLE, 32'h00020000);
        sm.pulse(0);
        rdchk(`OFS_STATUS, 32'h00080000);
        irqchk(1'b0);
        apb(1'b1, `OFS_STATUS, 32'h00080000);
        // wrap lands in the commit cycle of the clearing write
        fork
            apb(1'b1, `OFS_STATUS, 32'h00080000);
            begin
                repeat (2) @(posedge clock);
                sm.pulse(0);
            end
        join
        rdchk(`OFS_STATUS, 32'h00080000);
        apb(1'b1, `OFS_STATUS, 32'h00080000);
        rdchk(`OFS_STATUS, 32'h00000000);
        sm.level(1'b0, 1'b0, 1'b0, 1'b1);
        sm.pulse(1);
        irqchk(1'b1);
        apb(1'b1, `OFS_STATUS, 32'h00020000);
        rdchk(`OFS_STATUS, 32'h00020000);
        sm.level(1'b0, 1'b0, 1'b0, 1'b0);
        apb(1'b1, `OFS_STATUS, 32'h00020000);
        rdchk(`OFS_STATUS, 32'h00000000);
        irqchk(1'b0);
    endtask

    initial
    begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        repeat (12) @(posedge clock);
        t_reset;
        t_map;
        t_soft;
        t_mirror;
        t_wake;
        give_verdict;
    end

    // the whole sequence needs fewer than two hundred cycles
    initial
    begin
        repeat (3000) @(posedge clock);
        mismatches++;
        give_verdict;
    end
endmodule
